// ### logic/owdr_consts.vh
// Constants for the single-wire dimming receiver
`ifndef OWDR_CONSTS_VH
`define OWDR_CONSTS_VH

// Clock rate in MHz
`define OWDR_CLK_MHZ       40
// Line-low time that forces shutdown, ns (least time)
`define OWDR_SHUT_NS       2500000
// Longest acknowledge pulldown time, ns
`define OWDR_ACK_PULSE_NS  512000
// Internal delay from last falling edge to pulldown, ns
`define OWDR_ACK_DELAY_NS  2000
// Bit counts and field positions of the data byte
`define OWDR_BYTE_BITS     8
`define OWDR_ACK_REQ_BIT   7
`define OWDR_SUB_HI_BIT    6
`define OWDR_SUB_LO_BIT    5
`define OWDR_LEVEL_MSB     4
// Level code held after power reset (full scale)
`define OWDR_LEVEL_RST     5'h1F

`endif

// ### logic/owdr_rx.v
// Single-wire dimming protocol receiver with open-drain acknowledge
`timescale 1ns/1ps
`default_nettype none
`include "owdr_consts.vh"

// How it works
// - Address byte then data byte; act on ID match
// - Data: ack flag, two zero sub-address bits, level
// - Bits arrive and shift in MSB first
// - Already-high line needs no start before address
// - Bit period spans falling edge to falling edge
// - Longer high means one; longer phase twice shorter
// - Acknowledge only if requested, matched, all valid
// - Pulldown after fixed delay, held bounded time
// - Rate-independent decoding, 1.7 to 160 kbit/s
// - Level kept in register, full scale on reset
// - Line low beyond 2.5 ms forces shutdown
module owdr_rx
#(
   parameter [7:0] TARGET_ID     = 8'hA5, // Arbitrary value
   parameter       CNT_W         = 16,
   parameter       SHUT_CYC      = (`OWDR_SHUT_NS * `OWDR_CLK_MHZ + 999)
                                   / 1000,
   parameter       ACK_PULSE_CYC = (`OWDR_ACK_PULSE_NS * `OWDR_CLK_MHZ)
                                   / 1000
)
(
   // Clock and reset
   input  wire       CLK_IN,
   input  wire       ARST_N_IN,
   // Control line, open drain
   input  wire       CTRL_IN,
   output wire       CTRL_OUT,
   output wire       CTRL_OE_OUT,
   // Dimming state
   output wire [4:0] LEVEL_CODE_OUT,
   output wire       LEVEL_UPDATE_OUT,
   output wire       SHUTDOWN_OUT,
   output wire       FRAME_ERR_OUT
);

   localparam ACK_DELAY_CYC =
      (`OWDR_ACK_DELAY_NS * `OWDR_CLK_MHZ + 999) / 1000;
   localparam ST_IDLE = 6'h01;
   localparam ST_BITS = 6'h02;
   localparam ST_GAP  = 6'h04;
   localparam ST_AWT  = 6'h08;
   localparam ST_AHLD = 6'h10;
   localparam ST_SHUT = 6'h20;
   localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
   // Integer copies, cut on purpose to the 20-bit counters
   localparam integer SHUT_I   = SHUT_CYC;
   localparam integer DLY_I    = ACK_DELAY_CYC;
   localparam integer LEN_I    = ACK_PULSE_CYC;
   localparam [19:0]  SHUT_LIM = SHUT_I[19:0];
   localparam [19:0]  ACK_DLY  = DLY_I[19:0];
   localparam [19:0]  ACK_LEN  = LEN_I[19:0];

   // Longer phase must be at least twice the shorter one
   function ratio_ok;
      input [CNT_W-1:0] h;
      input [CNT_W-1:0] l;
      begin
         if (h > l)
            ratio_ok = ({1'b0, h} >= {l, 1'b0});
         else
            ratio_ok = ({1'b0, l} >= {h, 1'b0});
      end
   endfunction

   reg             sync1_r;
   reg             ctrl_s_r;
   reg             prev_r;
   reg [5:0]       state_r;
   reg [CNT_W-1:0] high_cnt_r;
   reg [CNT_W-1:0] low_cnt_r;
   reg [19:0]      shut_cnt_r;
   reg [19:0]      ack_cnt_r;
   reg [2:0]       bit_cnt_r;
   reg             byte_sel_r;
   reg [7:0]       shift_r;
   reg [7:0]       addr_r;
   reg             err_r;
   reg [4:0]       level_r;
   reg             upd_r;
   reg             shut_r;
   reg             oe_r;
   reg             ferr_r;
   reg             ctrl_out_r;

   wire       fall    = prev_r & ~ctrl_s_r;
   wire       bit_val = (high_cnt_r > low_cnt_r);
   wire       bit_bad = ~ratio_ok(high_cnt_r, low_cnt_r);
   wire [7:0] byte_v  = {shift_r[6:0], bit_val};
   wire       last    = (bit_cnt_r == 3'h7);
   wire       frm_ok  = (addr_r == TARGET_ID) & ~err_r & ~bit_bad
                        & ~byte_v[`OWDR_SUB_HI_BIT]
                        & ~byte_v[`OWDR_SUB_LO_BIT];
   wire       low_long = (shut_cnt_r >= SHUT_LIM);

   // Two-stage synchroniser; only the second stage feeds logic
   always @(posedge CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         sync1_r  <= 1'b0;
         ctrl_s_r <= 1'b0;
         prev_r   <= 1'b0;
      end
      else
      begin
         sync1_r  <= CTRL_IN;
         ctrl_s_r <= sync1_r;
         prev_r   <= ctrl_s_r;
      end
   end

   // Phase timers restart at every falling edge; saturate, no wrap
   always @(posedge CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         high_cnt_r <= {CNT_W{1'b0}};
         low_cnt_r  <= {CNT_W{1'b0}};
         shut_cnt_r <= 20'h00000;
      end
      else
      begin
         if (fall)
         begin
            high_cnt_r <= {CNT_W{1'b0}};
            low_cnt_r  <= {{(CNT_W-1){1'b0}}, 1'b1};
         end
         else if (ctrl_s_r)
         begin
            if (high_cnt_r != CNT_MAX)
               high_cnt_r <= high_cnt_r + 1'b1;
         end
         else if (low_cnt_r != CNT_MAX)
            low_cnt_r <= low_cnt_r + 1'b1;
         // Own pulldown must not count toward shutdown
         if (ctrl_s_r | oe_r)
            shut_cnt_r <= 20'h00000;
         else if (!low_long)
            shut_cnt_r <= shut_cnt_r + 20'h00001;
      end
   end

   // Frame sequencer
   always @(posedge CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         state_r    <= ST_SHUT;
         bit_cnt_r  <= 3'h0;
         byte_sel_r <= 1'b0;
         shift_r    <= 8'h00;
         addr_r     <= 8'h00;
         err_r      <= 1'b0;
         level_r    <= `OWDR_LEVEL_RST;
         upd_r      <= 1'b0;
         shut_r     <= 1'b1;
         oe_r       <= 1'b0;
         ferr_r     <= 1'b0;
         ack_cnt_r  <= 20'h00000;
         ctrl_out_r <= 1'b0;
      end
      else
      begin
         upd_r  <= 1'b0;
         ferr_r <= 1'b0;
         shut_r <= 1'b0;
         case (state_r)
            ST_SHUT:
            begin
               shut_r <= ~ctrl_s_r;
               if (ctrl_s_r)
                  state_r <= ST_IDLE;
            end
            // Line idles high: first fall starts a bit, no start needed
            ST_IDLE:
            begin
               if (fall)
               begin
                  state_r    <= ST_BITS;
                  bit_cnt_r  <= 3'h0;
                  byte_sel_r <= 1'b0;
                  err_r      <= 1'b0;
               end
            end
            ST_BITS:
            begin
               if (fall)
               begin
                  shift_r   <= byte_v;
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  if (bit_bad)
                     err_r <= 1'b1;
                  if (last && !byte_sel_r)
                  begin
                     addr_r  <= byte_v;
                     state_r <= ST_GAP;
                  end
                  else if (last)
                  begin
                     ferr_r <= ~frm_ok;
                     // Commit only once both bytes check out
                     if (frm_ok)
                     begin
                        level_r <= byte_v[`OWDR_LEVEL_MSB:0];
                        upd_r   <= 1'b1;
                     end
                     ack_cnt_r <= 20'h00000;
                     if (frm_ok && byte_v[`OWDR_ACK_REQ_BIT])
                        state_r <= ST_AWT;
                     else
                        state_r <= ST_IDLE;
                  end
               end
               else if (high_cnt_r == CNT_MAX)
                  state_r <= ST_IDLE;
            end
            // End-of-stream low, then start high, then data byte
            ST_GAP:
            begin
               if (fall)
               begin
                  state_r    <= ST_BITS;
                  bit_cnt_r  <= 3'h0;
                  byte_sel_r <= 1'b1;
               end
            end
            ST_AWT:
            begin
               ack_cnt_r <= ack_cnt_r + 20'h00001;
               if (ack_cnt_r >= ACK_DLY - 20'h00001)
               begin
                  oe_r      <= 1'b1;
                  ack_cnt_r <= 20'h00000;
                  state_r   <= ST_AHLD;
               end
            end
            ST_AHLD:
            begin
               ack_cnt_r <= ack_cnt_r + 20'h00001;
               if (ack_cnt_r >= ACK_LEN - 20'h00001)
               begin
                  oe_r    <= 1'b0;
                  state_r <= ST_IDLE;
               end
            end
            default:
               state_r <= ST_SHUT;
         endcase
         // Long low ends any frame; own pulldown is excluded
         if (low_long && !state_r[4] && !state_r[5])
         begin
            state_r <= ST_SHUT;
            shut_r  <= 1'b1;
            upd_r   <= 1'b0;
         end
      end
   end

   assign CTRL_OUT         = ctrl_out_r;
   assign CTRL_OE_OUT      = oe_r;
   assign LEVEL_CODE_OUT   = level_r;
   assign LEVEL_UPDATE_OUT = upd_r;
   assign SHUTDOWN_OUT     = shut_r;
   assign FRAME_ERR_OUT    = ferr_r;

endmodule // owdr_rx

`default_nettype wire

// ### bench/owdr_rx_properties.sv
// Port-level assertions for the dimming receiver
`timescale 1ns/1ps
`default_nettype none
module owdr_rx_properties
#(
   parameter SHUT_CYC      = 500,
   parameter ACK_PULSE_CYC = 50
)
(
   // Clock, reset and line
   input wire logic       CLK_IN,
   input wire logic       ARST_N_IN,
   input wire logic       CTRL_IN,
   // Observed outputs
   input wire logic       CTRL_OUT,
   input wire logic       CTRL_OE_OUT,
   input wire logic [4:0] LEVEL_CODE_OUT,
   input wire logic       LEVEL_UPDATE_OUT,
   input wire logic       SHUTDOWN_OUT,
   input wire logic       FRAME_ERR_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   int oe_cnt_r;
   int age_r;
   int low_r;
   // Age and low counters saturate, so a long idle cannot wrap
   always @(posedge CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         oe_cnt_r <= 0;
         age_r    <= 1000;
         low_r    <= 0;
      end
      else
      begin
         oe_cnt_r <= CTRL_OE_OUT ? oe_cnt_r + 1 : 0;
         age_r    <= LEVEL_UPDATE_OUT ? 0 : age_r + (age_r < 1000);
         // Frozen while the device itself pulls low
         low_r <= CTRL_IN ? 0 : low_r + (!CTRL_OE_OUT && low_r < 2 * SHUT_CYC);
      end
   end
   a_od_data_low: assert property (CTRL_OUT == 1'b0)
      else $error("open-drain data not low");
   a_ack_len_exact: assert property ($fell(CTRL_OE_OUT) |->
      oe_cnt_r == ACK_PULSE_CYC) else $error("pulldown length wrong");
   a_ack_after_commit: assert property ($rose(CTRL_OE_OUT) |->
      age_r inside {[70:90]}) else $error("pulldown not after commit");
   a_level_on_commit: assert property ($changed(LEVEL_CODE_OUT) |->
      LEVEL_UPDATE_OUT) else $error("level moved without commit");
   a_commit_not_err: assert property
      (!(LEVEL_UPDATE_OUT && FRAME_ERR_OUT)) else $error("commit and reject");
   a_commit_one_cyc: assert property (LEVEL_UPDATE_OUT |=>
      !LEVEL_UPDATE_OUT) else $error("commit pulse too long");
   a_err_one_cyc: assert property (FRAME_ERR_OUT |=>
      !FRAME_ERR_OUT) else $error("reject pulse too long");
   a_shut_long_low: assert property (low_r > SHUT_CYC + 8 |->
      SHUTDOWN_OUT) else $error("no shutdown on long low");
   a_shut_not_early: assert property ($rose(SHUTDOWN_OUT) |->
      low_r >= SHUT_CYC) else $error("shutdown too early");
endmodule // owdr_rx_properties
`default_nettype wire

// ### bench/owdr_master.sv
// Behavioural open-drain master for the dimming line
`timescale 1ns/1ps
`default_nettype none
module owdr_master
(
   input  wire logic clk_in,
   input  wire logic line_in,
   output var  logic low_out
);
   // Open drain only pulls low; the pull-up gives high
   initial low_out = 1'b0;
   task automatic hold(input logic v, input int n);
      low_out = !v;
      repeat (n) @(negedge clk_in);
   endtask
   task automatic put_byte(input logic [7:0] b, input int l, h);
      hold(1'b1, 100); // Start high before the byte
      for (int i = 7; i >= 0; i--) // MSB first
      begin
         hold(1'b0, b[i] ? l : h); // Longer phase sets the bit
         hold(1'b1, b[i] ? h : l);
      end
      hold(1'b0, 100); // End of stream closes the last bit
   endtask
   task automatic send(input logic [7:0] a, d, input int l, h,
                       output logic ack);
      put_byte(a, l, h); // Address first
      put_byte(d, l, h); // Then the data byte
      hold(1'b1, 10); // Release after the delay, then read
      ack = !line_in;
      hold(1'b1, 90); // Wait out the pulldown
   endtask
endmodule // owdr_master
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the dimming receiver
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
   $display("CHECK FAILED at %0t: value mismatch", $time); end end
module tb_top;
   localparam [7:0] ID = 8'hC6; // Arbitrary value
   logic       CLK_IN    = 1'b0;
   logic       ARST_N_IN = 1'b0;
   wire        mst_low;
   wire        oe;
   wire        line = !(oe | mst_low);
   wire  [4:0] level;
   wire        upd;
   wire        err;
   wire        shut;
   int         n_errors = 0;
   int         checks = 0;
   int         cyc = 0;
   int         n_upd, n_err, n_oe;
   always #12.5 CLK_IN = !CLK_IN;
   // Short phase timers so a stalled line times out quickly
   owdr_rx #(.TARGET_ID(ID), .CNT_W(10), .SHUT_CYC(500),
      .ACK_PULSE_CYC(50)) u_owdr_rx (
      .CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .CTRL_IN(line), .CTRL_OUT(),
      .CTRL_OE_OUT(oe), .LEVEL_CODE_OUT(level), .LEVEL_UPDATE_OUT(upd),
      .SHUTDOWN_OUT(shut), .FRAME_ERR_OUT(err));
   owdr_master u_owdr_master (.clk_in(CLK_IN), .line_in(line),
      .low_out(mst_low));
   // Pulse tallies and the run ceiling; an unknown counts as a pulse
   always @(posedge CLK_IN)
   begin
      n_upd += (upd !== 1'b0);
      n_err += (err !== 1'b0);
      n_oe += (oe !== 1'b0);
      if (++cyc == 40000)
      begin
         n_errors++;
         finish_test();
      end
   end
   task automatic frame(input logic [7:0] a, d, input int l, h,
                        input logic [4:0] lv, input int u, e);
      logic ak;
      n_upd = 0;
      n_err = 0;
      n_oe = 0;
      u_owdr_master.send(a, d, l, h, ak);
      `CHK(level, lv) // Stored level
      `CHK(n_upd, u) // Commit count
      `CHK(n_err, e) // Reject count
      `CHK(n_oe, (u && d[7]) ? 50 : 0) // Pulldown cycles
      `CHK(ak, u && d[7]) // Read back low
   endtask
   task automatic t_reset;
      `CHK(level, 5'h1F) // Full scale in reset
      `CHK(shut, 1'b1) // Asleep in reset
      ARST_N_IN = 1'b1;
      repeat (20) @(negedge CLK_IN);
      `CHK(shut, 1'b0) // High line wakes it
   endtask
   task automatic t_ack;
      frame(ID, 8'h8A, 10, 30, 5'h0A, 1, 0); // With ack
   endtask
   task automatic t_noack;
      frame(ID, 8'h15, 10, 30, 5'h15, 1, 0); // No ack flag
   endtask
   task automatic t_bad_id;
      frame(8'h63, 8'h81, 10, 30, 5'h15, 0, 1); // Mirrored ID
   endtask
   task automatic t_sub;
      frame(ID, 8'hC1, 10, 30, 5'h15, 0, 1); // High sub bit
      frame(ID, 8'hA1, 10, 30, 5'h15, 0, 1); // Low sub bit
   endtask
   task automatic t_ratio;
      frame(ID, 8'h81, 20, 30, 5'h15, 0, 1); // Ratio under two
   endtask
   task automatic t_rate;
      frame(ID, 8'h9F, 80, 170, 5'h1F, 1, 0); // 160 kbit/s bits
   endtask
   task automatic t_shut;
      u_owdr_master.put_byte(ID, 10, 30);
      u_owdr_master.hold(1'b0, 600);
      `CHK(shut, 1'b1) // Long low mid-frame
      u_owdr_master.hold(1'b1, 20);
      `CHK(shut, 1'b0) // Wakes on high
      frame(ID, 8'h03, 10, 30, 5'h03, 1, 0); // Half frame dropped
   endtask
   task automatic t_stall;
      n_upd = 0;
      n_err = 0;
      u_owdr_master.hold(1'b0, 10);
      u_owdr_master.hold(1'b1, 1100);
      `CHK(n_upd + n_err, 0) // Stalled byte dropped silently
      frame(ID, 8'h05, 10, 30, 5'h05, 1, 0); // Realigned after stall
   endtask
   task automatic t_rst;
      ARST_N_IN = 1'b0;
      repeat (12) @(negedge CLK_IN);
      t_reset();
      frame(ID, 8'h0C, 10, 30, 5'h0C, 1, 0); // Usable after reset
   endtask
   task automatic finish_test;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Main sequence after 12 cycles of reset
   initial
   begin
      repeat (12) @(negedge CLK_IN);
      t_reset();
      t_ack();
      t_noack();
      t_bad_id();
      t_sub();
      t_ratio();
      t_rate();
      t_stall();
      t_shut();
      t_rst();
      finish_test();
   end
endmodule // tb_top
bind owdr_rx owdr_rx_properties #(.SHUT_CYC(SHUT_CYC),
   .ACK_PULSE_CYC(ACK_PULSE_CYC)) u_owdr_rx_properties (.CLK_IN(CLK_IN),
   .ARST_N_IN(ARST_N_IN), .CTRL_IN(CTRL_IN), .CTRL_OUT(CTRL_OUT),
   .CTRL_OE_OUT(CTRL_OE_OUT), .LEVEL_CODE_OUT(LEVEL_CODE_OUT),
   .LEVEL_UPDATE_OUT(LEVEL_UPDATE_OUT), .SHUTDOWN_OUT(SHUTDOWN_OUT),
   .FRAME_ERR_OUT(FRAME_ERR_OUT));
`default_nettype wire
